// ===== hdl/vem_regs.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "vem_params.svh"
module vem_regs
  import vem_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sine/cosine task strobe
  input wire logic sincos_run,
  // engine-facing settings
  output vem_mode_s mode_out,
  output vem_calc_s calc_out,
  output logic three_phase_sense,
  output logic shift1_speed_use,
  output logic shift_combo_err
);
  logic [1:0] shift_mode_ff;
  logic [1:0] sense_ff;
  logic shift_en_ff;
  logic c2p_ff;
  logic interp_ff;
  logic [15:0] ratio_ff;
  logic [15:0] speed_ff;
  logic [15:0] phase_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  vem_mode_s mode_ff;
  vem_calc_s calc_ff;
  logic three_ff;
  logic s1spd_ff;
  logic cerr_ff;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [31:0] nxt_rdata;
  logic [15:0] nxt_phase;
  logic signed [31:0] step_prod;

  // writes land on the pready edge only, so a stalled master never commits early;
  // reads are captured one edge earlier so prdata can come straight from a flop
  assign wr_acc = psel & penable & pwrite & pready_ff;
  assign rd_acc = psel & penable & ~pwrite & ~pready_ff;

  // address decode
  always_comb
  begin
    mapped = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      `VEM_OFS_FLOW_MODE:
      begin
        nxt_rdata[`VEM_BIT_SHIFT_MD_HI:`VEM_BIT_SHIFT_MD_LO] = shift_mode_ff;
        nxt_rdata[`VEM_BIT_SENSE_HI:`VEM_BIT_SENSE_LO] = sense_ff;
        nxt_rdata[`VEM_BIT_SHIFT_EN] = shift_en_ff;
        nxt_rdata[`VEM_BIT_C2P] = c2p_ff;
      end
      `VEM_OFS_PERIOD_RATIO: nxt_rdata[15:0] = ratio_ff;
      `VEM_OFS_ROT_SPEED: nxt_rdata[15:0] = speed_ff;
      `VEM_OFS_PHASE: nxt_rdata[15:0] = phase_ff;
      `VEM_OFS_ENGINE_CTRL: nxt_rdata[`VEM_BIT_INTERP_EN] = interp_ff;
      default: mapped = 1'b0;
    endcase
  end

  // apb answer regs: one wait state keeps prdata a flop
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped & `VEM_PSLVERR_UNMAPPED;
      if (rd_acc)
        prdata_ff <= nxt_rdata;
      else
        prdata_ff <= 32'h0000_0000;
    end
  end

  // mode fields; code meaning decoded downstream
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      shift_mode_ff <= 2'h0;
      sense_ff <= 2'h0;
      shift_en_ff <= 1'b0;
      c2p_ff <= 1'b0;
      interp_ff <= 1'b0;
    end
    else if (clk_en && wr_acc)
    begin
      if (paddr == `VEM_OFS_FLOW_MODE)
      begin
        shift_mode_ff <= pwdata[`VEM_BIT_SHIFT_MD_HI:`VEM_BIT_SHIFT_MD_LO];
        sense_ff <= pwdata[`VEM_BIT_SENSE_HI:`VEM_BIT_SENSE_LO];
        shift_en_ff <= pwdata[`VEM_BIT_SHIFT_EN];
        c2p_ff <= pwdata[`VEM_BIT_C2P];
      end
      if (paddr == `VEM_OFS_ENGINE_CTRL)
        interp_ff <= pwdata[`VEM_BIT_INTERP_EN];
    end
  end

  // parameter words, upper bits dropped on write
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ratio_ff <= `VEM_RST_WORD16;
      speed_ff <= `VEM_RST_WORD16;
    end
    else if (clk_en && wr_acc)
    begin
      if (paddr == `VEM_OFS_PERIOD_RATIO)
        ratio_ff <= pwdata[15:0];
      if (paddr == `VEM_OFS_ROT_SPEED)
        speed_ff <= pwdata[15:0];
    end
  end

  // phase step: signed speed (Q15) times unsigned ratio (Q16), scaled to Q16 turn
  assign step_prod = $signed(speed_ff) * $signed({1'b0, ratio_ff[15:1]});
  assign nxt_phase = phase_ff + step_prod[30:15];

  // phase: software write beats the engine update in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      phase_ff <= `VEM_RST_WORD16;
    else if (clk_en)
    begin
      if (wr_acc && paddr == `VEM_OFS_PHASE)
        phase_ff <= pwdata[15:0];
      else if (sincos_run && interp_ff)
        phase_ff <= nxt_phase;
    end
  end

  // registered engine outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_ff <= '0;
      calc_ff <= '0;
      three_ff <= 1'b1;
      s1spd_ff <= 1'b0;
      cerr_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_ff <= {shift_mode_ff, vem_sense_e'(sense_ff), shift_en_ff, c2p_ff};
      calc_ff.period_ratio_value <= interp_ff ? ratio_ff : 16'h0000;
      calc_ff.rotation_speed_value <= interp_ff ? speed_ff : 16'h0000;
      calc_ff.phase_angle_value <= phase_ff;
      calc_ff.phase_interpolation_enable <= interp_ff;
      three_ff <= (sense_ff == VEM_SENSE_THREE_SHUNT);
      s1spd_ff <= sense_ff[1] & shift_en_ff & (shift_mode_ff == 2'h0);
      // flags illegal shift/modulation pairs; hardware cannot fix them
      cerr_ff <= shift_en_ff & ((shift_mode_ff == 2'h0) ? ~c2p_ff : c2p_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mode_out = mode_ff;
  assign calc_out = calc_ff;
  assign three_phase_sense = three_ff;
  assign shift1_speed_use = s1spd_ff;
  assign shift_combo_err = cerr_ff;

  property p_rdy_one;
    @(posedge clk) disable iff (reset) (clk_en && psel && penable && !pready) |=> pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready late");
  property p_hi_zero;
    @(posedge clk) disable iff (reset) pready && paddr != `VEM_OFS_FLOW_MODE |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_interp_off;
    @(posedge clk) disable iff (reset) (clk_en && !interp_ff && !wr_acc) |=> $stable(phase_ff);
  endproperty
  a_interp_off: assert property (p_interp_off) else $error("phase moved");
  property p_phase_upd;
    @(posedge clk) disable iff (reset) (clk_en && sincos_run && interp_ff && !wr_acc)
      |=> phase_ff == $past(nxt_phase);
  endproperty
  a_phase_upd: assert property (p_phase_upd) else $error("phase step wrong");
  property p_ratio_wr;
    @(posedge clk) disable iff (reset) (clk_en && wr_acc && paddr == `VEM_OFS_PERIOD_RATIO)
      |=> ratio_ff == $past(pwdata[15:0]);
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("ratio not written");
  property p_three;
    @(posedge clk) disable iff (reset) clk_en |=> three_phase_sense == ($past(sense_ff) == 2'h0);
  endproperty
  a_three: assert property (p_three) else $error("sense decode");
  property p_calc_gate;
    @(posedge clk) disable iff (reset) (clk_en && !interp_ff) |=> calc_out.period_ratio_value == 16'h0000;
  endproperty
  a_calc_gate: assert property (p_calc_gate) else $error("ratio leaked");
  property p_combo;
    @(posedge clk) disable iff (reset) (clk_en && shift_en_ff && shift_mode_ff == 2'h0 && c2p_ff)
      |=> !shift_combo_err;
  endproperty
  a_combo: assert property (p_combo) else $error("legal pair flagged");
  // shift 2 with two-phase modulation is never a legal pairing
  property p_shift2_pair;
    @(posedge clk) disable iff (reset) (clk_en && shift_en_ff && shift_mode_ff != 2'h0 && c2p_ff)
      |=> shift_combo_err;
  endproperty
  a_shift2_pair: assert property (p_shift2_pair) else $error("illegal pair missed");
  // speed goes to the first output task only in single-shunt shift 1
  property p_speed_use;
    @(posedge clk) disable iff (reset) clk_en
      |=> shift1_speed_use == ($past(sense_ff[1] && shift_en_ff && shift_mode_ff == 2'h0));
  endproperty
  a_speed_use: assert property (p_speed_use) else $error("speed use decode");
  // frozen clock enable must hold the phase whatever the strobe does
  property p_freeze;
    @(posedge clk) disable iff (reset) !clk_en |=> $stable(phase_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved while frozen");
  c_shift2: cover property (@(posedge clk) shift_en_ff && shift_mode_ff != 2'h0 && !c2p_ff);
  c_write: cover property (@(posedge clk) wr_acc ##2 rd_acc);
  c_interp: cover property (@(posedge clk) sincos_run && interp_ff);
  c_err: cover property (@(posedge clk) pslverr);
endmodule // vem_regs

// ===== include/vem_params.svh
`ifndef VEM_PARAMS_SVH
`define VEM_PARAMS_SVH
`define VEM_OFS_FLOW_MODE 12'h000
`define VEM_OFS_PERIOD_RATIO 12'h004
`define VEM_OFS_ROT_SPEED 12'h008
`define VEM_OFS_PHASE 12'h00C
`define VEM_OFS_ENGINE_CTRL 12'h010
`define VEM_BIT_C2P 0
`define VEM_BIT_SHIFT_EN 1
`define VEM_BIT_SENSE_LO 2
`define VEM_BIT_SENSE_HI 3
`define VEM_BIT_SHIFT_MD_LO 14
`define VEM_BIT_SHIFT_MD_HI 15
`define VEM_BIT_INTERP_EN 0
`define VEM_RST_WORD16 16'h0000
`define VEM_RST_MODE 4'h0
`define VEM_PSLVERR_UNMAPPED 1'b1
`endif

// ===== include/vem_pkg.sv
package vem_pkg;
  typedef enum logic [1:0] {
    VEM_SENSE_THREE_SHUNT = 2'h0,
    VEM_SENSE_TWO_SENSOR = 2'h1,
    VEM_SENSE_ONE_SHUNT_UP = 2'h2,
    VEM_SENSE_ONE_SHUNT_DN = 2'h3
  } vem_sense_e;
  typedef struct packed {
    logic [1:0] shift_mode;
    vem_sense_e sense;
    logic pwm_shift_enable;
    logic two_phase_modulation_select;
  } vem_mode_s;
  typedef struct packed {
    logic [15:0] period_ratio_value;
    logic [15:0] rotation_speed_value;
    logic [15:0] phase_angle_value;
    logic phase_interpolation_enable;
  } vem_calc_s;
endpackage

// ===== dv/vem_regs_bench.sv
`timescale 1ns/100ps
`include "vem_params.svh"
module vem_regs_bench
  import vem_pkg::*;
;
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic sincos_run = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, three_phase_sense, shift1_speed_use, shift_combo_err;
  vem_mode_s mode_out;
  vem_calc_s calc_out;
  int error_cnt = 0;
  int checks = 0;
  // device under test; clk_en dropped once to check the freeze
  vem_regs u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sincos_run(sincos_run), .mode_out(mode_out), .calc_out(calc_out),
    .three_phase_sense(three_phase_sense), .shift1_speed_use(shift1_speed_use),
    .shift_combo_err(shift_combo_err));
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one apb transfer; leading edge keeps back-to-back calls from double driving
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic ee, input string nm);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (!wr) `CHK(nm, e, prdata)
    `CHK("pslverr", ee, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0, "wr");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0, e, 1'b0, nm);
  endtask
  // single sine/cosine strobe, then let the outputs settle
  task automatic run_pulse();
    @(posedge clk);
    sincos_run <= 1'b1;
    @(posedge clk);
    sincos_run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // hang guard, far above the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("sense3", 1'b1, three_phase_sense)
    rd(`VEM_OFS_FLOW_MODE, 32'h0, "flow rst");
    rd(`VEM_OFS_PERIOD_RATIO, 32'h0, "ratio rst");
    rd(`VEM_OFS_ROT_SPEED, 32'h0, "speed rst");
    rd(`VEM_OFS_PHASE, 32'h0, "phase rst");
    wr(`VEM_OFS_FLOW_MODE, 32'hFFFFFFFF);
    rd(`VEM_OFS_FLOW_MODE, 32'h0000C00F, "flow bits");
    // every sense code; shift enabled, shift mode 1
    for (int i = 0; i < 4; i++)
    begin
      wr(`VEM_OFS_FLOW_MODE, {28'h0, i[1:0], 2'b10});
      repeat (2) @(posedge clk);
      `CHK("sense", i[1:0], mode_out.sense)
      `CHK("sense3", 1'(i == 0), three_phase_sense)
      `CHK("spd use", i[1], shift1_speed_use)
    end
    // modulation and shift pairing table
    for (int j = 0; j < 8; j++)
    begin
      wr(`VEM_OFS_FLOW_MODE, {16'h0, 1'b0, j[2], 12'h0, j[1], j[0]});
      repeat (2) @(posedge clk);
      `CHK("c2p", j[0], mode_out.two_phase_modulation_select)
      `CHK("shen", j[1], mode_out.pwm_shift_enable)
      `CHK("combo", j[1] & (j[2] ? j[0] : ~j[0]), shift_combo_err)
    end
    // value registers keep only the low half
    wr(`VEM_OFS_PERIOD_RATIO, 32'hFFFF8000);
    wr(`VEM_OFS_ROT_SPEED, 32'hABCD0100);
    wr(`VEM_OFS_PHASE, 32'h1234FFF0);
    rd(`VEM_OFS_PERIOD_RATIO, 32'h00008000, "ratio");
    rd(`VEM_OFS_ROT_SPEED, 32'h00000100, "speed");
    run_pulse();
    `CHK("ang off", 16'hFFF0, calc_out.phase_angle_value)
    `CHK("rat off", 16'h0000, calc_out.period_ratio_value)
    wr(`VEM_OFS_ENGINE_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("rat on", 16'h8000, calc_out.period_ratio_value)
    `CHK("spd on", 16'h0100, calc_out.rotation_speed_value)
    // step 0x100 * 0x4000 >> 15 = 0x80, wraps past full turn
    run_pulse();
    rd(`VEM_OFS_PHASE, 32'h00000070, "phase up");
    wr(`VEM_OFS_ROT_SPEED, 32'h0000FF00);
    run_pulse();
    rd(`VEM_OFS_PHASE, 32'h0000FFF0, "phase dn");
    `CHK("ang on", 16'hFFF0, calc_out.phase_angle_value)
    // strobe while frozen: phase must not move
    @(posedge clk);
    clk_en <= 1'b0;
    sincos_run <= 1'b1;
    repeat (2) @(posedge clk);
    clk_en <= 1'b1;
    sincos_run <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("frozen", 16'hFFF0, calc_out.phase_angle_value)
    // single-shunt up count, shift 2, three-phase: legal pairing, timer set by software
    wr(`VEM_OFS_FLOW_MODE, 32'h0000400A);
    repeat (2) @(posedge clk);
    `CHK("combo s2", 1'b0, shift_combo_err)
    `CHK("spd s2", 1'b0, shift1_speed_use)
    // mid-run reset clears every field
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`VEM_OFS_PHASE, 32'h0, "phase rst2");
    rd(`VEM_OFS_FLOW_MODE, 32'h0, "flow rst2");
    rd(`VEM_OFS_ENGINE_CTRL, 32'h0, "ctrl rst2");
    // unmapped word refuses and reads zero
    xfer(1'b1, 12'h020, 32'hFFFFFFFF, 32'h0, 1'b1, "bad wr");
    xfer(1'b0, 12'h020, 32'h0, 32'h0, 1'b1, "bad rd");
    stop_test();
  end
endmodule // vem_regs_bench
